//--- rpp_system.sv
// system end: power-good sequencing, bus reset timing, straps, responses with parity
`include "rpp_defs.svh"

module rpp_system #(
	parameter int SETTLE_CYCLES = `RPP_SETTLE_CYC,
	parameter int POR_CYCLES = `RPP_POR_CYC,
	parameter int RST_MAX_CYCLES = `RPP_RST_MAX_CYC,
	parameter int WARM_CYCLES = `RPP_WARM_CYC
) (
	input wire logic mclk,
	input wire logic reset_n,
	rpp_if.sys bus,
	input wire logic supply_ok,
	input wire logic scan_active,
	input wire logic warm_reset_req,
	input wire rpp_pkg::rpp_cfg_t cfg_strap,
	input wire logic sys_owns,
	input wire logic req_valid,
	input wire rpp_pkg::rpp_req_t req_cmd,
	input wire logic resp_valid,
	input wire rpp_pkg::rpp_rs_t resp_status,
	input wire logic resp_bad_parity,
	output logic sys_ready,
	output logic req_ready,
	output logic resp_ready,
	output logic obs_valid,
	output rpp_pkg::rpp_req_t obs_cmd,
	output logic cpu_present
);
	import rpp_pkg::*;

	localparam rpp_cnt_t SETTLE_LIM = rpp_cnt_t'(SETTLE_CYCLES);
	// hold time clamped below the ceiling so a long setting cannot break it
	localparam int HOLD_POR = (POR_CYCLES < RST_MAX_CYCLES) ? POR_CYCLES : RST_MAX_CYCLES - 1;
	localparam int HOLD_WARM = (WARM_CYCLES < RST_MAX_CYCLES) ? WARM_CYCLES : RST_MAX_CYCLES - 1;
	localparam rpp_cnt_t POR_LIM = rpp_cnt_t'(HOLD_POR);
	localparam rpp_cnt_t WARM_LIM = rpp_cnt_t'(HOLD_WARM);

	rpp_sys_state_t state;
	rpp_sys_state_t next_state;
	rpp_cnt_t cnt;
	logic sup_meta;
	logic sup_sync;
	logic skt_meta;
	logic skt_sync;
	logic pg_q;
	logic rst_q;
	logic rst_seen;
	rpp_req_t req_o;
	logic req_oe;
	logic strobe_o;
	rpp_rs_t rs_o;
	logic rsp_o;
	logic rs_oe;

	// in power-on reset, run and warm reset, supply lost matters only while no boundary scan is running
	wire supply_drop = !sup_sync && !scan_active;
	wire settle_done = cnt >= SETTLE_LIM;
	wire por_done = cnt >= POR_LIM;
	wire warm_done = cnt >= WARM_LIM;
	wire in_run = state == RPP_SYS_RUN;
	wire req_take = in_run && sys_owns && req_valid && req_ready && !bus.dev_req_oe;
	wire resp_take = in_run && resp_valid && resp_ready && (resp_status != '0);
	wire [`RPP_RS_W-1:0] rs_lines = ~resp_status;
	// even count of low lines gives a high parity line
	wire rsp_good = ~(^(~rs_lines));
	wire dev_strobe = !bus.addr_strobe_0_n && bus.dev_req_oe;

	assign bus.power_good = pg_q;
	assign bus.bus_reset_n = rst_q;
	assign bus.cfg_n = ~cfg_strap;
	assign bus.sys_req_o = req_o;
	assign bus.sys_req_oe = req_oe;
	assign bus.sys_strobe_o = strobe_o;
	assign bus.sys_rs_o = rs_o;
	assign bus.sys_rsp_o = rsp_o;
	assign bus.sys_rs_oe = rs_oe;

	// supply and socket pins come from outside the clock domain
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			sup_meta <= 1'b0;
			sup_sync <= 1'b0;
			skt_meta <= 1'b1;
			skt_sync <= 1'b1;
		end else begin
			sup_meta <= supply_ok;
			sup_sync <= sup_meta;
			skt_meta <= bus.socket_present_n;
			skt_sync <= skt_meta;
		end
	end

	// sequencing: off, settle, power-on reset, run, warm reset
	always_comb begin
		next_state = state;
		unique case (state)
			RPP_SYS_OFF: begin
				if (sup_sync)
					next_state = RPP_SYS_SETTLE;
			end
			RPP_SYS_SETTLE: begin
				if (!sup_sync)
					next_state = RPP_SYS_OFF;
				else if (settle_done)
					next_state = RPP_SYS_POR;
			end
			RPP_SYS_POR: begin
				if (supply_drop)
					next_state = RPP_SYS_OFF;
				else if (por_done)
					next_state = RPP_SYS_RUN;
			end
			RPP_SYS_RUN: begin
				if (supply_drop)
					next_state = RPP_SYS_OFF;
				else if (warm_reset_req)
					next_state = RPP_SYS_WARM;
			end
			RPP_SYS_WARM: begin
				if (supply_drop)
					next_state = RPP_SYS_OFF;
				else if (warm_done)
					next_state = RPP_SYS_RUN;
			end
			default: next_state = RPP_SYS_OFF;
		endcase
	end

	// state and the one shared counter, cleared on every state change
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state <= RPP_SYS_OFF;
			cnt <= '0;
		end else begin
			state <= next_state;
			cnt <= (next_state != state) ? '0 : cnt + rpp_cnt_t'(1);
		end
	end

	// power_good and reset lines, both registered so they never glitch
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			pg_q <= 1'b0;
			rst_q <= 1'b0;
			rst_seen <= 1'b1;
		end else begin
			pg_q <= (next_state == RPP_SYS_POR) || (next_state == RPP_SYS_RUN)
				|| (next_state == RPP_SYS_WARM);
			rst_q <= next_state == RPP_SYS_RUN;
			rst_seen <= !rst_q;
		end
	end

	// request drive; dropped within one clock when reset goes active
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			req_o <= `RPP_REQ_IDLE;
			req_oe <= 1'b0;
			strobe_o <= 1'b1;
		end else if (!rst_q || rst_seen) begin
			req_o <= `RPP_REQ_IDLE;
			req_oe <= 1'b0;
			strobe_o <= 1'b1;
		end else begin
			req_o <= req_take ? ~req_cmd : `RPP_REQ_IDLE;
			req_oe <= req_take;
			strobe_o <= !req_take;
		end
	end

	// response drive, parity on the same cycle as the status lines
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			rs_o <= `RPP_RS_IDLE;
			rsp_o <= 1'b1;
			rs_oe <= 1'b0;
		end else if (!rst_q || rst_seen) begin
			rs_o <= `RPP_RS_IDLE;
			rsp_o <= 1'b1;
			rs_oe <= 1'b0;
		end else begin
			rs_o <= resp_take ? rs_lines : `RPP_RS_IDLE;
			// bad parity injection lets the device checker be exercised
			rsp_o <= resp_take ? (rsp_good ^ resp_bad_parity) : 1'b1;
			rs_oe <= resp_take;
		end
	end

	// user handshakes: one transfer, then a cycle idle before the next
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			sys_ready <= 1'b0;
			req_ready <= 1'b0;
			resp_ready <= 1'b0;
		end else begin
			sys_ready <= next_state == RPP_SYS_RUN;
			// held off in the first run cycle, while the drivers are still blanked
			req_ready <= (next_state == RPP_SYS_RUN) && !req_take && rst_q;
			resp_ready <= (next_state == RPP_SYS_RUN) && !resp_take && rst_q;
		end
	end

	// watch the device's requests and its presence pin
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			obs_valid <= 1'b0;
			obs_cmd <= '0;
			cpu_present <= 1'b0;
		end else begin
			obs_valid <= dev_strobe;
			obs_cmd <= dev_strobe ? ~bus.req_cmd_n : obs_cmd;
			cpu_present <= !skt_sync;
		end
	end
endmodule : rpp_system

//--- rpp_defs.svh
// timing counts and line levels shared by both ends of the reset and response link
`ifndef RPP_DEFS_SVH
`define RPP_DEFS_SVH

`define RPP_CLK_MHZ 100
`define RPP_T_POR_US 1000
`define RPP_T_RST_MAX_US 10000
`define RPP_POR_CYC (((`RPP_T_POR_US * `RPP_CLK_MHZ) > 0) ? (`RPP_T_POR_US * `RPP_CLK_MHZ) : 1)
`define RPP_RST_MAX_CYC (`RPP_T_RST_MAX_US * `RPP_CLK_MHZ)
`define RPP_RELEASE_CLKS 2
`define RPP_SETTLE_CYC 16
`define RPP_WARM_CYC 16
`define RPP_CNT_W 20
`define RPP_REQ_W 5
`define RPP_RS_W 3
`define RPP_CFG_W 5
`define RPP_RS_IDLE 3'h7
`define RPP_REQ_IDLE 5'h1f

`endif

//--- rpp_pkg.sv
// types shared by the device end and the system end
`include "rpp_defs.svh"

package rpp_pkg;
	typedef logic [`RPP_REQ_W-1:0] rpp_req_t;
	typedef logic [`RPP_RS_W-1:0] rpp_rs_t;
	typedef logic [`RPP_CFG_W-1:0] rpp_cfg_t;
	typedef logic [`RPP_CNT_W-1:0] rpp_cnt_t;

	typedef enum logic [2:0] {
		RPP_SYS_OFF = 3'b000,
		RPP_SYS_SETTLE = 3'b001,
		RPP_SYS_POR = 3'b010,
		RPP_SYS_RUN = 3'b011,
		RPP_SYS_WARM = 3'b100
	} rpp_sys_state_t;

	typedef enum logic [1:0] {
		RPP_DEV_RESET = 2'b00,
		RPP_DEV_IDLE = 2'b01,
		RPP_DEV_DRIVE = 2'b10
	} rpp_dev_state_t;
endpackage : rpp_pkg

//--- rpp_if.sv
// bus wires between the device end and the system end, resolved from the drive enables
`include "rpp_defs.svh"

interface rpp_if;
	import rpp_pkg::*;
	logic power_good;
	logic bus_reset_n;
	rpp_cfg_t cfg_n;
	rpp_req_t dev_req_o;
	logic dev_req_oe;
	logic dev_strobe_o;
	rpp_req_t sys_req_o;
	logic sys_req_oe;
	logic sys_strobe_o;
	rpp_rs_t sys_rs_o;
	logic sys_rsp_o;
	logic sys_rs_oe;
	logic socket_present_n;
	rpp_req_t req_cmd_n;
	logic addr_strobe_0_n;
	rpp_rs_t response_status_n;
	logic response_parity_n;

	// undriven lines float to the pulled-up idle level
	assign req_cmd_n = dev_req_oe ? dev_req_o : (sys_req_oe ? sys_req_o : `RPP_REQ_IDLE);
	assign addr_strobe_0_n = dev_req_oe ? dev_strobe_o : (sys_req_oe ? sys_strobe_o : 1'b1);
	assign response_status_n = sys_rs_oe ? sys_rs_o : `RPP_RS_IDLE;
	assign response_parity_n = sys_rs_oe ? sys_rsp_o : 1'b1;

	modport dev (
		input power_good, bus_reset_n, cfg_n, req_cmd_n, addr_strobe_0_n,
		input response_status_n, response_parity_n,
		output dev_req_o, dev_req_oe, dev_strobe_o, socket_present_n
	);
	modport sys (
		output power_good, bus_reset_n, cfg_n, sys_req_o, sys_req_oe, sys_strobe_o,
		output sys_rs_o, sys_rsp_o, sys_rs_oe,
		input req_cmd_n, addr_strobe_0_n, socket_present_n, dev_req_oe
	);
endinterface : rpp_if

//--- rpp_device.sv
// device end: reset response, configuration capture, requests and response parity check
`include "rpp_defs.svh"

module rpp_device (
	input wire logic mclk,
	input wire logic reset_n,
	rpp_if.dev bus,
	input wire logic tx_valid,
	input wire rpp_pkg::rpp_req_t tx_cmd,
	input wire logic bus_grant,
	output logic tx_ready,
	output logic in_reset,
	output logic cache_inval,
	output rpp_pkg::rpp_cfg_t cfg_word,
	output logic cfg_valid,
	output logic rsp_valid,
	output rpp_pkg::rpp_rs_t rsp_status,
	output logic parity_err
);
	import rpp_pkg::*;

	rpp_dev_state_t state;
	rpp_dev_state_t next_state;
	logic bus_rst_q;
	rpp_req_t req_o;
	logic req_oe;
	logic strobe_o;
	logic skt_q;

	// power_good low counts as reset as well
	wire held = !bus.bus_reset_n || !bus.power_good;
	wire held_rise = held && !bus_rst_q;
	wire release_edge = !held && bus_rst_q;
	wire take = (state == RPP_DEV_IDLE) && tx_valid && tx_ready && bus_grant;
	wire rs_active = bus.response_status_n != `RPP_RS_IDLE;
	// correct parity: high for an even count of low status lines, so idle 111 reads high
	wire rsp_expect = ~(^(~bus.response_status_n));
	wire rsp_bad = rs_active && (bus.response_parity_n != rsp_expect);

	assign bus.dev_req_o = req_o;
	assign bus.dev_req_oe = req_oe;
	assign bus.dev_strobe_o = strobe_o;
	assign bus.socket_present_n = skt_q;

	// state choice; reset wins over any transfer in flight
	always_comb begin
		next_state = state;
		unique case (state)
			RPP_DEV_RESET: begin
				if (release_edge)
					next_state = RPP_DEV_IDLE;
			end
			RPP_DEV_IDLE: begin
				if (held)
					next_state = RPP_DEV_RESET;
				else if (take)
					next_state = RPP_DEV_DRIVE;
			end
			RPP_DEV_DRIVE: begin
				next_state = held ? RPP_DEV_RESET : RPP_DEV_IDLE;
			end
			default: next_state = RPP_DEV_RESET;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state <= RPP_DEV_RESET;
			bus_rst_q <= 1'b1;
		end else begin
			state <= next_state;
			bus_rst_q <= held;
		end
	end

	// bus drivers: dropped one clock after reset is seen, inside the two-clock limit
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			req_o <= `RPP_REQ_IDLE;
			req_oe <= 1'b0;
			strobe_o <= 1'b1;
		end else if (held) begin
			req_o <= `RPP_REQ_IDLE;
			req_oe <= 1'b0;
			strobe_o <= 1'b1;
		end else if (take) begin
			req_o <= ~tx_cmd;
			req_oe <= 1'b1;
			strobe_o <= 1'b0;
		end else begin
			req_o <= `RPP_REQ_IDLE;
			req_oe <= 1'b0;
			strobe_o <= 1'b1;
		end
	end

	// socket pin stays grounded for board presence detect
	always_ff @(posedge mclk) begin
		skt_q <= 1'b0;
	end

	// handshake and reset view for the core side
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			tx_ready <= 1'b0;
			in_reset <= 1'b1;
			cache_inval <= 1'b0;
		end else begin
			tx_ready <= (next_state == RPP_DEV_IDLE) && !take;
			in_reset <= held;
			// invalidate pulse only; no write-back is ever requested
			cache_inval <= held_rise;
		end
	end

	// configuration latched at the active-to-inactive reset edge
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			cfg_word <= '0;
			cfg_valid <= 1'b0;
		end else if (held) begin
			cfg_valid <= 1'b0;
		end else if (release_edge) begin
			cfg_word <= ~bus.cfg_n;
			cfg_valid <= 1'b1;
		end
	end

	// response capture and parity check, one result per active cycle
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			rsp_valid <= 1'b0;
			rsp_status <= '0;
			parity_err <= 1'b0;
		end else begin
			rsp_valid <= rs_active && !held;
			rsp_status <= rs_active ? ~bus.response_status_n : rsp_status;
			parity_err <= rsp_bad && !held;
		end
	end
endmodule : rpp_device

//--- rpp_checker.sv
// concurrent checks on the resolved reset, request and response wires
module rpp_checker #(
	parameter int POR_CYCLES = 20,
	parameter int RST_MAX_CYCLES = 40
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic power_good,
	input wire logic bus_reset_n,
	input wire logic dev_req_oe,
	input wire logic sys_req_oe,
	input wire logic sys_rs_oe,
	input wire logic socket_present_n,
	input wire logic addr_strobe_0_n,
	input wire rpp_pkg::rpp_rs_t response_status_n,
	input wire logic response_parity_n
);
	import rpp_pkg::*;
	int low_cnt;
	logic por_phase;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	// length of bus reset under power good; warm resets never see power good low
	always_ff @(posedge mclk) begin
		if (!reset_n || bus_reset_n || !power_good) begin
			low_cnt <= 0;
		end else begin
			low_cnt <= low_cnt + 1;
		end
	end

	// set when power good was low during this reset, so it counts as power-on
	always_ff @(posedge mclk) begin
		if (!reset_n || bus_reset_n) begin
			por_phase <= 1'b0;
		end else if (!power_good) begin
			por_phase <= 1'b1;
		end
	end

	a_socket_tied_low: assert property (socket_present_n == 1'b0)
		else $error("socket present line not low");
	a_dev_released: assert property (!bus_reset_n [*3] |-> !dev_req_oe)
		else $error("device still drives in bus reset");
	a_sys_released: assert property (!bus_reset_n [*3] |-> !sys_req_oe && !sys_rs_oe)
		else $error("system still drives in bus reset");
	a_strobe_single: assert property ($fell(addr_strobe_0_n) |=> addr_strobe_0_n)
		else $error("request strobe longer than one cycle");
	a_strobe_owned: assert property (!addr_strobe_0_n |->
		bus_reset_n && (dev_req_oe || sys_req_oe))
		else $error("strobe without an owner");
	a_idle_parity_high: assert property (response_status_n == 3'h7 |-> response_parity_n)
		else $error("idle status with parity low");
	a_resp_one_cycle: assert property (sys_rs_oe |-> response_status_n != 3'h7 ##1 !sys_rs_oe)
		else $error("response drive malformed");
	a_pg_in_reset: assert property ($rose(power_good) |-> !bus_reset_n ##1 !bus_reset_n)
		else $error("power good rose outside reset");
	a_por_long_enough: assert property ($rose(bus_reset_n) && por_phase |-> low_cnt >= POR_CYCLES)
		else $error("power-on reset too short");
	a_reset_bounded: assert property (low_cnt < RST_MAX_CYCLES)
		else $error("bus reset held too long");

	cover property ($rose(bus_reset_n) && por_phase);
	cover property ($rose(bus_reset_n) && !por_phase);
	cover property ($fell(addr_strobe_0_n) && dev_req_oe);
	cover property (sys_rs_oe && !response_parity_n);
endmodule : rpp_checker

//--- reset_powergood_response_parity_bench.sv
// self-checking bench joining the device end and the system end
module reset_powergood_response_parity_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import rpp_pkg::*;
	logic mclk = 0, reset_n = 0, supply_ok = 0, scan_active = 0, warm_reset_req = 0;
	logic sys_owns = 0, req_valid = 0, resp_valid = 0, resp_bad_parity = 0, tx_valid = 0;
	logic bus_grant = 0, tx_ready, in_reset, cache_inval, cfg_valid, rsp_valid, parity_err;
	logic sys_ready, req_ready, resp_ready, obs_valid, cpu_present;
	rpp_cfg_t cfg_strap = 0, strap, cfg_word;
	rpp_req_t req_cmd = 0, tx_cmd = 0, obs_cmd;
	rpp_rs_t resp_status = 1, rsp_status;
	int miscompares = 0, checks_done = 0, cycles = 0, inval_cnt = 0, base = 0, seed = 60, n;
	rpp_req_t q_req[$];
	rpp_req_t q_obs[$];
	rpp_req_t exp_req;
	rpp_rs_t exp_rs;
	logic [3:0] q_rsp[$];

	rpp_if bus_if();
	rpp_device i_rpp_device (.mclk(mclk), .reset_n(reset_n), .bus(bus_if), .tx_valid(tx_valid),
		.tx_cmd(tx_cmd), .bus_grant(bus_grant), .tx_ready(tx_ready), .in_reset(in_reset),
		.cache_inval(cache_inval), .cfg_word(cfg_word), .cfg_valid(cfg_valid),
		.rsp_valid(rsp_valid), .rsp_status(rsp_status), .parity_err(parity_err));
	rpp_system #(.SETTLE_CYCLES(4), .POR_CYCLES(20), .RST_MAX_CYCLES(40), .WARM_CYCLES(4))
		i_rpp_system (.mclk(mclk), .reset_n(reset_n), .bus(bus_if), .supply_ok(supply_ok),
		.scan_active(scan_active), .warm_reset_req(warm_reset_req), .cfg_strap(cfg_strap),
		.sys_owns(sys_owns), .req_valid(req_valid), .req_cmd(req_cmd), .resp_valid(resp_valid),
		.resp_status(resp_status), .resp_bad_parity(resp_bad_parity), .sys_ready(sys_ready),
		.req_ready(req_ready), .resp_ready(resp_ready), .obs_valid(obs_valid),
		.obs_cmd(obs_cmd), .cpu_present(cpu_present));
	rpp_checker i_rpp_checker (.mclk(mclk),
		.reset_n(reset_n), .power_good(bus_if.power_good), .bus_reset_n(bus_if.bus_reset_n),
		.dev_req_oe(bus_if.dev_req_oe), .sys_req_oe(bus_if.sys_req_oe),
		.sys_rs_oe(bus_if.sys_rs_oe), .socket_present_n(bus_if.socket_present_n),
		.addr_strobe_0_n(bus_if.addr_strobe_0_n), .response_status_n(bus_if.response_status_n),
		.response_parity_n(bus_if.response_parity_n));

	always #5 mclk = ~mclk;

	task check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : print_verdict

	// one selector so a single bounded wait serves every handshake and level
	function logic rdy(input int k);
		case (k)
			0: rdy = tx_ready;
			1: rdy = req_ready;
			2: rdy = resp_ready;
			3: rdy = sys_ready;
			4: rdy = in_reset;
			5: rdy = ~in_reset;
			default: rdy = ~bus_if.power_good;
		endcase
	endfunction : rdy

	task wait_rdy(input int k);
		for (n = 0; n < 500 && rdy(k) !== 1'b1; n++) @(negedge mclk);
	endtask : wait_rdy

	// request held from a falling edge until ready is seen, taken at the next rising edge
	task dev_req(input rpp_req_t c);
		@(negedge mclk);
		tx_cmd = c;
		tx_valid = 1;
		bus_grant = 1;
		wait_rdy(0);
		q_req.push_back(c);
		q_obs.push_back(c);
		@(negedge mclk);
		tx_valid = 0;
		bus_grant = 0;
	endtask : dev_req

	task sys_req(input rpp_req_t c);
		@(negedge mclk);
		req_cmd = c;
		req_valid = 1;
		sys_owns = 1;
		wait_rdy(1);
		q_req.push_back(c);
		@(negedge mclk);
		req_valid = 0;
		sys_owns = 0;
	endtask : sys_req

	task resp(input rpp_rs_t st, input logic bad);
		@(negedge mclk);
		resp_status = st;
		resp_bad_parity = bad;
		resp_valid = 1;
		wait_rdy(2);
		q_rsp.push_back({bad, st});
		@(negedge mclk);
		resp_valid = 0;
	endtask : resp

	// watchers: wires and device outputs against the oldest note
	always @(negedge mclk) begin
		// inversions go through narrow variables so no upper bits are set
		if (reset_n && bus_if.addr_strobe_0_n === 1'b0) begin
			exp_req = ~q_req.pop_front();
			check(bus_if.req_cmd_n, exp_req);
		end
		if (reset_n && obs_valid === 1'b1) begin
			check(obs_cmd, q_obs.pop_front());
		end
		if (reset_n && bus_if.sys_rs_oe === 1'b1) begin
			exp_rs = ~q_rsp[0][2:0];
			check(bus_if.response_status_n, exp_rs);
			check(bus_if.response_parity_n, (~^q_rsp[0][2:0]) ^ q_rsp[0][3]);
		end
		if (reset_n && rsp_valid === 1'b1) begin
			check(rsp_status, q_rsp[0][2:0]);
			check(parity_err, q_rsp.pop_front() >> 3);
		end
	end

	// pulse count and hang limit; the full run needs well under 3000 cycles
	always @(posedge mclk) begin
		cycles++;
		if (cache_inval === 1'b1) inval_cnt++;
		if (cycles == 20000) begin
			miscompares++;
			print_verdict();
		end
	end

	initial begin
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		reset_n = 1;
		strap = rpp_cfg_t'($random(seed));
		cfg_strap = strap;
		supply_ok = 1;
		wait_rdy(3);
		check(sys_ready, 1);
		// the device sees the release one clock after the system raises it
		wait_rdy(5);
		check(cfg_valid, 1);
		check(cfg_word, strap);
		check(in_reset, 0);
		check(cpu_present, 1);
		for (int i = 0; i < 6; i++) begin
			dev_req(rpp_req_t'($random(seed)));
			dev_req(rpp_req_t'($random(seed)));
			sys_req(rpp_req_t'($random(seed)));
		end
		for (int i = 1; i < 8; i++) begin
			resp(rpp_rs_t'(i), 1'b0);
			resp(rpp_rs_t'(i), 1'b1);
		end
		// warm reset: new straps must be taken at release, caches dropped once
		base = inval_cnt;
		strap = rpp_cfg_t'($random(seed));
		cfg_strap = strap;
		warm_reset_req = 1;
		@(negedge mclk);
		warm_reset_req = 0;
		wait_rdy(4);
		check(cfg_valid, 0);
		check(bus_if.power_good, 1);
		wait_rdy(5);
		@(negedge mclk);
		check(cfg_word, strap);
		check(inval_cnt - base, 1);
		// supply drop during scan must not drop power good until the scan ends
		scan_active = 1;
		supply_ok = 0;
		repeat (10) @(negedge mclk);
		check(bus_if.power_good, 1);
		scan_active = 0;
		wait_rdy(6);
		@(negedge mclk);
		check(in_reset, 1);
		check(bus_if.bus_reset_n, 0);
		supply_ok = 1;
		wait_rdy(5);
		@(negedge mclk);
		check(cfg_valid, 1);
		check(inval_cnt - base, 2);
		dev_req(5'h0a);
		resp(3'h5, 1'b0);
		repeat (4) @(negedge mclk);
		// a transfer that never showed up leaves its note behind
		check(q_req.size(), 0);
		check(q_obs.size(), 0);
		check(q_rsp.size(), 0);
		print_verdict();
	end
endmodule : reset_powergood_response_parity_bench
